// File: logic/ucb_pkg.sv
// ucb_pkg: register map, field positions, reset values, delay-insertion ranks and carrier structs
// assumes a byte-wide register port with 16-bit addresses and a single clock domain
package ucb_pkg;

	// register addresses
	localparam logic [15:0] UCB_TXD_ADDR  = 16'h4101;
	localparam logic [15:0] UCB_RXD_ADDR  = 16'h4102;
	localparam logic [15:0] UCB_CTL_ADDR  = 16'h4104;
	localparam logic [15:0] UCB_EXP_ADDR  = 16'h4105;
	localparam logic [15:0] UCB_BR_ADDR   = 16'h4106;
	localparam logic [15:0] UCB_FMD_ADDR  = 16'h4107;
	localparam logic [15:0] UCB_IST_ADDR  = 16'h4108;

	// channel_interrupt_control fields; the status register shares bits 7..4
	localparam int UCB_TX_END_BIT   = 7;
	localparam int UCB_RX_ERR_BIT   = 6;
	localparam int UCB_RX_FULL_BIT  = 5;
	localparam int UCB_TX_EMPTY_BIT = 4;
	localparam int UCB_THRESH_BIT   = 1;
	localparam int UCB_ENABLE_BIT   = 0;
	localparam int UCB_IRQ_LO       = 4;
	localparam int UCB_IRQ_NUM      = 4;
	localparam int UCB_IR_BIT       = 0;

	// writable-bit masks; reserved bits read as zero
	localparam logic [7:0] UCB_CTL_MASK = 8'hf3;
	localparam logic [7:0] UCB_EXP_MASK = 8'h01;
	localparam logic [7:0] UCB_FMD_MASK = 8'h0f;
	localparam logic [7:0] UCB_IST_MASK = 8'hf0;
	localparam logic [7:0] UCB_REG_RST  = 8'h00;

	// receive store
	localparam logic [1:0] UCB_RX_DEPTH = 2'h2;

	// underflow positions per bit; index 0 is position 1, index 15 is position 16
	localparam logic [3:0] UCB_POS_LAST = 4'hf;
	// a position gets a delay when its rank is below fine_adjust
	localparam logic [3:0] UCB_RANK [16] = '{4'hf, 4'h7, 4'hb, 4'h3, 4'hd, 4'h5, 4'h9, 4'h1,
	                                         4'he, 4'h6, 4'ha, 4'h2, 4'hc, 4'h4, 4'h8, 4'h0};

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ucb_bus_req_type;

	typedef struct packed {
		logic        tx_start;
		logic        tx_done;
		logic        rx_error;
		logic        rx_push;
		logic [7:0]  rx_data;
	} ucb_link_evt_type;

endpackage

// File: logic/ucb_ctrl_baud.sv
// ucb_ctrl_baud: control registers, interrupt requests, receive store, transmit holding byte and baud generator
// assumes the framing logic reports its events on link_evt_in and a count-clock tick arrives as a one-cycle enable
// Overview of operation
// - a completed transmission raises a request only when tx_end_irq_enable is 1, which it is not after reset.
// - a receive error raises a request only when rx_error_irq_enable is 1, default 0.
// - the receive buffer reaching its threshold raises a request only when rx_full_irq_enable is 1, default 0.
// - the holding byte moving to the shifter raises a request when tx_empty_irq_enable is 1.
// - rx_full_threshold 0 means one held byte is full, 1 means two held bytes.
// - transfers happen only while channel_enable is 1, and it resets to 0.
// - writing 0 to channel_enable also discards the waiting transmit byte.
// - infrared_mode_select 1 turns the infrared function on; 0, the reset value, gives a plain port.
// - the baud counter loads the 8-bit reload value, counts down to underflow and repeats; reload resets to 0.
// - bit rate is count clock over sixteen times reload plus one, plus fine_adjust.
// - the 4-bit fine_adjust, reset 0, sets how many delays occur in each sixteen underflows.
// - each delay lengthens one output clock cycle by exactly one count clock cycle.
// - delays fill positions 16, 8, 12, 4, 14, 6, 10, 2, 15, 7, 11, 3, 13, 5, 9 in that order, first n used.
// - the receive buffer is a two-entry fifo with a one-held and a two-held flag.
module ucb_ctrl_baud #(
	parameter int BAUD_W = 8
) (
	// clock, reset, freeze
	input  wire logic                      ref_clk_in,
	input  wire logic                      resetn_in,
	input  wire logic                      ce_in,
	// register port
	input  wire ucb_pkg::ucb_bus_req_type  bus_req_in,
	output logic [7:0]                     bus_rdata_out,
	// framing side
	input  wire ucb_pkg::ucb_link_evt_type link_evt_in,
	input  wire logic                      count_tick_in,
	output logic [7:0]                     tx_data_out,
	output logic                           tx_valid_out,
	output logic                           rx_one_ready_flag_out,
	output logic                           rx_two_ready_flag_out,
	output logic                           channel_enable_out,
	output logic                           infrared_mode_select_out,
	output logic                           sample_tick_out,
	output logic                           bit_tick_out,
	// interrupt controller side
	output logic                           tx_end_irq_out,
	output logic                           rx_error_irq_out,
	output logic                           rx_full_irq_out,
	output logic                           tx_empty_irq_out,
	output logic                           irq_out
);

	if (BAUD_W < 1 || BAUD_W > 8)
	begin : g_bad_width
		$error("BAUD_W must lie between 1 and 8");
	end

	// register group
	logic [7:0]        ctl_r, ctl_nxt;
	logic [7:0]        exp_r, exp_nxt;
	logic [BAUD_W-1:0] br_r, br_nxt;
	logic [7:0]        fmd_r, fmd_nxt;
	logic [7:0]        ist_r, ist_nxt;
	logic [7:0]        txd_r, txd_nxt;
	logic              txv_r, txv_nxt;
	logic [7:0]        rdata_r, rdata_nxt;
	logic [7:0]        mem_r [2];
	logic [7:0]        mem_nxt [2];
	logic              rdp_r, rdp_nxt;
	logic              wrp_r, wrp_nxt;
	logic [1:0]        cnt_r, cnt_nxt;
	logic              chan_en;
	logic              wr_ctl;
	logic              pop_any;
	localparam int UCB_IRQ_NUM_W = ucb_pkg::UCB_IRQ_NUM;
	logic [UCB_IRQ_NUM_W-1:0] irq_vec;

	assign chan_en = ctl_r[ucb_pkg::UCB_ENABLE_BIT];
	assign wr_ctl  = bus_req_in.wr && bus_req_in.addr == ucb_pkg::UCB_CTL_ADDR;

	always_comb
	begin
		logic       push;
		logic       pop;
		logic [1:0] cnt_after;
		logic [7:0] sets;
		push      = 1'b0;
		pop       = 1'b0;
		cnt_after = cnt_r;
		sets      = 8'h00;
		ctl_nxt   = ctl_r;
		exp_nxt   = exp_r;
		br_nxt    = br_r;
		fmd_nxt   = fmd_r;
		txd_nxt   = txd_r;
		txv_nxt   = txv_r;
		rdata_nxt = 8'h00;
		mem_nxt   = mem_r;
		rdp_nxt   = rdp_r;
		wrp_nxt   = wrp_r;
		// link events count only while the channel runs
		if (chan_en)
		begin
			sets[ucb_pkg::UCB_TX_END_BIT] = link_evt_in.tx_done;
			sets[ucb_pkg::UCB_RX_ERR_BIT] = link_evt_in.rx_error;
			if (link_evt_in.tx_start && txv_r)
			begin
				sets[ucb_pkg::UCB_TX_EMPTY_BIT] = 1'b1;
				txv_nxt                         = 1'b0;
			end
			// a push into a full store is dropped; overrun is the framer's to flag
			push = link_evt_in.rx_push && cnt_r < ucb_pkg::UCB_RX_DEPTH;
		end
		pop = bus_req_in.rd && bus_req_in.addr == ucb_pkg::UCB_RXD_ADDR && cnt_r != 2'h0;
		if (push)
		begin
			mem_nxt[wrp_r] = link_evt_in.rx_data;
			wrp_nxt        = ~wrp_r;
		end
		if (pop)
		begin
			rdp_nxt = ~rdp_r;
		end
		cnt_after = cnt_r + {1'b0, push} - {1'b0, pop};
		if (push)
		begin
			if (ctl_r[ucb_pkg::UCB_THRESH_BIT])
				sets[ucb_pkg::UCB_RX_FULL_BIT] = (cnt_after == ucb_pkg::UCB_RX_DEPTH);
			else
				sets[ucb_pkg::UCB_RX_FULL_BIT] = 1'b1;
		end
		if (bus_req_in.wr)
		begin
			unique case (bus_req_in.addr)
				ucb_pkg::UCB_CTL_ADDR:
				begin
					ctl_nxt = bus_req_in.wdata & ucb_pkg::UCB_CTL_MASK;
					if (!bus_req_in.wdata[ucb_pkg::UCB_ENABLE_BIT])
						txv_nxt = 1'b0;
				end
				ucb_pkg::UCB_TXD_ADDR:
				begin
					txd_nxt = bus_req_in.wdata;
					txv_nxt = 1'b1;
				end
				ucb_pkg::UCB_EXP_ADDR: exp_nxt = bus_req_in.wdata & ucb_pkg::UCB_EXP_MASK;
				ucb_pkg::UCB_BR_ADDR:  br_nxt  = bus_req_in.wdata[BAUD_W-1:0];
				ucb_pkg::UCB_FMD_ADDR: fmd_nxt = bus_req_in.wdata & ucb_pkg::UCB_FMD_MASK;
				default: ;
			endcase
		end
		if (bus_req_in.rd)
		begin
			unique case (bus_req_in.addr)
				ucb_pkg::UCB_TXD_ADDR: rdata_nxt = txd_r;
				ucb_pkg::UCB_RXD_ADDR: rdata_nxt = (cnt_r != 2'h0) ? mem_r[rdp_r] : ucb_pkg::UCB_REG_RST;
				ucb_pkg::UCB_CTL_ADDR: rdata_nxt = ctl_r;
				ucb_pkg::UCB_EXP_ADDR: rdata_nxt = exp_r;
				ucb_pkg::UCB_BR_ADDR:  rdata_nxt = 8'(br_r);
				ucb_pkg::UCB_FMD_ADDR: rdata_nxt = fmd_r;
				ucb_pkg::UCB_IST_ADDR: rdata_nxt = ist_r;
				default:               rdata_nxt = ucb_pkg::UCB_REG_RST;
			endcase
		end
		// read clears the status, but an event in the same cycle still lands
		if (bus_req_in.rd && bus_req_in.addr == ucb_pkg::UCB_IST_ADDR)
			ist_nxt = sets & ucb_pkg::UCB_IST_MASK;
		else
			ist_nxt = (ist_r | sets) & ucb_pkg::UCB_IST_MASK;
		cnt_nxt = cnt_after;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctl_r   <= ucb_pkg::UCB_REG_RST;
			exp_r   <= ucb_pkg::UCB_REG_RST;
			br_r    <= '0;
			fmd_r   <= ucb_pkg::UCB_REG_RST;
			ist_r   <= ucb_pkg::UCB_REG_RST;
			txd_r   <= ucb_pkg::UCB_REG_RST;
			txv_r   <= 1'b0;
			rdata_r <= ucb_pkg::UCB_REG_RST;
			mem_r   <= '{default: 8'h00};
			rdp_r   <= 1'b0;
			wrp_r   <= 1'b0;
			cnt_r   <= 2'h0;
		end
		else if (ce_in)
		begin
			ctl_r   <= ctl_nxt;
			exp_r   <= exp_nxt;
			br_r    <= br_nxt;
			fmd_r   <= fmd_nxt;
			ist_r   <= ist_nxt;
			txd_r   <= txd_nxt;
			txv_r   <= txv_nxt;
			rdata_r <= rdata_nxt;
			mem_r   <= mem_nxt;
			rdp_r   <= rdp_nxt;
			wrp_r   <= wrp_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// per-cause request: sticky cause gated by its enable, no extra flop
	for (genvar i = 0; i < ucb_pkg::UCB_IRQ_NUM; i++)
	begin : g_irq
		assign irq_vec[i] = ist_r[ucb_pkg::UCB_IRQ_LO+i] && ctl_r[ucb_pkg::UCB_IRQ_LO+i];
	end

	assign tx_end_irq_out   = irq_vec[ucb_pkg::UCB_TX_END_BIT-ucb_pkg::UCB_IRQ_LO];
	assign rx_error_irq_out = irq_vec[ucb_pkg::UCB_RX_ERR_BIT-ucb_pkg::UCB_IRQ_LO];
	assign rx_full_irq_out  = irq_vec[ucb_pkg::UCB_RX_FULL_BIT-ucb_pkg::UCB_IRQ_LO];
	assign tx_empty_irq_out = irq_vec[ucb_pkg::UCB_TX_EMPTY_BIT-ucb_pkg::UCB_IRQ_LO];
	assign irq_out          = |irq_vec;

	assign bus_rdata_out            = rdata_r;
	assign tx_data_out              = txd_r;
	assign tx_valid_out             = txv_r && chan_en;
	assign rx_one_ready_flag_out    = cnt_r != 2'h0;
	assign rx_two_ready_flag_out    = cnt_r == ucb_pkg::UCB_RX_DEPTH;
	assign channel_enable_out       = chan_en;
	assign infrared_mode_select_out = exp_r[ucb_pkg::UCB_IR_BIT];

	// baud group; gap, delay tally and settled feed only the checks below
	logic [BAUD_W-1:0] bcnt_r, bcnt_nxt;
	logic              dly_r, dly_nxt;
	logic [3:0]        pos_r, pos_nxt;
	logic [BAUD_W:0]   gap_r, gap_nxt;
	logic [3:0]        dseen_r, dseen_nxt;
	logic              settled_r, settled_nxt;
	logic              ins;
	logic              uflow;
	logic              rate_wr;

	assign ins     = ucb_pkg::UCB_RANK[pos_r] < fmd_r[3:0];
	assign uflow   = chan_en && count_tick_in && bcnt_r == '0 && !(ins && !dly_r);
	assign rate_wr = bus_req_in.wr && (bus_req_in.addr == ucb_pkg::UCB_BR_ADDR ||
	                 bus_req_in.addr == ucb_pkg::UCB_FMD_ADDR || bus_req_in.addr == ucb_pkg::UCB_CTL_ADDR);

	always_comb
	begin
		bcnt_nxt    = bcnt_r;
		dly_nxt     = dly_r;
		pos_nxt     = pos_r;
		gap_nxt     = gap_r;
		dseen_nxt   = dseen_r;
		settled_nxt = settled_r;
		if (!chan_en)
		begin
			bcnt_nxt  = br_r;
			dly_nxt   = 1'b0;
			pos_nxt   = 4'h0;
			gap_nxt   = '0;
			dseen_nxt = 4'h0;
		end
		else if (count_tick_in)
		begin
			gap_nxt = gap_r + 1'b1;
			if (bcnt_r != '0)
				bcnt_nxt = bcnt_r - 1'b1;
			else if (ins && !dly_r)
			begin
				// hold at zero for one extra count tick
				dly_nxt   = 1'b1;
				dseen_nxt = dseen_r + 4'h1;
			end
			else
			begin
				bcnt_nxt = br_r;
				dly_nxt  = 1'b0;
				pos_nxt  = pos_r + 4'h1;
				gap_nxt  = '0;
				if (pos_r == ucb_pkg::UCB_POS_LAST)
					dseen_nxt = 4'h0;
			end
		end
		// figures are trusted only after the next bit end with no rate change in between; after a mid-bit write that bit may be partial
		if (rate_wr || !chan_en)
			settled_nxt = 1'b0;
		else if (uflow && pos_r == ucb_pkg::UCB_POS_LAST)
			settled_nxt = 1'b1;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bcnt_r    <= '0;
			dly_r     <= 1'b0;
			pos_r     <= 4'h0;
			gap_r     <= '0;
			dseen_r   <= 4'h0;
			settled_r <= 1'b0;
		end
		else if (ce_in)
		begin
			bcnt_r    <= bcnt_nxt;
			dly_r     <= dly_nxt;
			pos_r     <= pos_nxt;
			gap_r     <= gap_nxt;
			dseen_r   <= dseen_nxt;
			settled_r <= settled_nxt;
		end
	end

	assign sample_tick_out = ce_in && uflow;
	assign bit_tick_out    = ce_in && uflow && pos_r == ucb_pkg::UCB_POS_LAST;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence s_txdone_armed;
		ce_in && link_evt_in.tx_done && chan_en && ctl_r[ucb_pkg::UCB_TX_END_BIT] && !wr_ctl;
	endsequence

	AST_TX_END_IRQ: assert property (s_txdone_armed |=> tx_end_irq_out)
		else $error("tx end request missing");
	AST_RX_ERR_MASKED: assert property (!ctl_r[ucb_pkg::UCB_RX_ERR_BIT] |-> !rx_error_irq_out)
		else $error("rx error request while disabled");
	AST_RX_FULL_ONE: assert property (ce_in && chan_en && link_evt_in.rx_push && cnt_r == 2'h0 &&
		!ctl_r[ucb_pkg::UCB_THRESH_BIT] |=> ist_r[ucb_pkg::UCB_RX_FULL_BIT])
		else $error("one-byte threshold did not flag full");
	AST_RX_FULL_TWO: assert property (ce_in && chan_en && link_evt_in.rx_push && cnt_r == 2'h0 && !pop_any &&
		ctl_r[ucb_pkg::UCB_THRESH_BIT] && !ist_r[ucb_pkg::UCB_RX_FULL_BIT] && !bus_req_in.wr
		|=> !ist_r[ucb_pkg::UCB_RX_FULL_BIT])
		else $error("two-byte threshold flagged early");
	AST_TX_EMPTY: assert property (ce_in && link_evt_in.tx_start && tx_valid_out && !bus_req_in.wr
		|=> !tx_valid_out && ist_r[ucb_pkg::UCB_TX_EMPTY_BIT])
		else $error("tx start did not empty the holding byte");
	AST_DISABLE_CLEARS: assert property (ce_in && wr_ctl && !bus_req_in.wdata[ucb_pkg::UCB_ENABLE_BIT]
		|=> !txv_r && !sample_tick_out)
		else $error("disable left the transmit byte");
	AST_GATED: assert property (!chan_en |-> !sample_tick_out && !tx_valid_out)
		else $error("activity while channel disabled");
	AST_IR_MODE: assert property (ce_in && bus_req_in.wr && bus_req_in.addr == ucb_pkg::UCB_EXP_ADDR
		|=> infrared_mode_select_out == $past(bus_req_in.wdata[ucb_pkg::UCB_IR_BIT]))
		else $error("infrared mode not taken");
	AST_PERIOD: assert property (sample_tick_out && settled_r |-> gap_r == BAUD_W'(br_r) + dly_r)
		else $error("baud period wrong");
	AST_DELAY_COUNT: assert property (bit_tick_out && settled_r |-> dseen_r == fmd_r[3:0])
		else $error("delay count per bit wrong");
	AST_FIFO_FLAGS: assert property (rx_two_ready_flag_out |-> rx_one_ready_flag_out)
		else $error("two-held flag without one-held flag");
	AST_ENABLE_AND: assert property (ce_in && wr_ctl && bus_req_in.wdata[7:4] == 4'h0 |=> !irq_out)
		else $error("request survived enable clear");

	assign pop_any = bus_req_in.rd && bus_req_in.addr == ucb_pkg::UCB_RXD_ADDR;

endmodule // ucb_ctrl_baud

// File: test/ucb_far_side.sv
// ucb_far_side: framing-side stand-in giving count-clock ticks at a chosen spacing and one-cycle link events
// assumes the bench pulses evt_req_in for one cycle per event and holds tick_div_in steady during a run
module ucb_far_side (
	// clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      resetn_in,
	// control from the bench
	input  wire logic [3:0]                tick_div_in,
	input  wire ucb_pkg::ucb_link_evt_type evt_req_in,
	// toward the block
	output logic                           count_tick_out,
	output ucb_pkg::ucb_link_evt_type      link_evt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	assign count_tick_out = (cnt_r == tick_div_in - 4'h1);
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cnt_r        <= 4'h0;
			link_evt_out <= '0;
		end
		else
		begin
			cnt_r        <= count_tick_out ? 4'h0 : cnt_r + 4'h1;
			link_evt_out <= evt_req_in;
			// data outside a push is not held, so a stale byte cannot pass for a fresh one
			if (!evt_req_in.rx_push)
				link_evt_out.rx_data <= ~link_evt_out.rx_data;
		end
	end
endmodule // ucb_far_side

// File: test/test_uart_ctrl_baud_generator.sv
// test_uart_ctrl_baud_generator: directed bench for the control, interrupt, receive store and baud logic
// assumes the register map and field layout of ucb_pkg and one 100 MHz clock
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_uart_ctrl_baud_generator;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      ref_clk_in = 1'b0;
	logic                      resetn_in  = 1'b0;
	ucb_pkg::ucb_bus_req_type  bus_req    = '0;
	ucb_pkg::ucb_link_evt_type evt_req    = '0;
	ucb_pkg::ucb_link_evt_type link_evt;
	logic [3:0]                tick_div   = 4'h1;
	logic                      ce         = 1'b1;
	logic                      count_tick;
	logic [7:0]                rdata, tx_data;
	logic                      tx_valid, one_rdy, two_rdy, chan_en, ir_mode, sample_tick, bit_tick;
	logic                      tx_end_irq, rx_err_irq, rx_full_irq, tx_empty_irq, irq;
	logic [3:0]                lines;
	int                        miscompares = 0;
	int                        check_count = 0;
	assign lines = {tx_end_irq, rx_err_irq, rx_full_irq, tx_empty_irq};
	always #5 ref_clk_in = ~ref_clk_in;

	ucb_far_side i_ucb_far_side (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .tick_div_in(tick_div),
		.evt_req_in(evt_req), .count_tick_out(count_tick), .link_evt_out(link_evt));
	ucb_ctrl_baud i_ucb_ctrl_baud (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce),
		.bus_req_in(bus_req), .bus_rdata_out(rdata), .link_evt_in(link_evt), .count_tick_in(count_tick),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid), .rx_one_ready_flag_out(one_rdy),
		.rx_two_ready_flag_out(two_rdy), .channel_enable_out(chan_en), .infrared_mode_select_out(ir_mode),
		.sample_tick_out(sample_tick), .bit_tick_out(bit_tick), .tx_end_irq_out(tx_end_irq),
		.rx_error_irq_out(rx_err_irq), .rx_full_irq_out(rx_full_irq), .tx_empty_irq_out(tx_empty_irq),
		.irq_out(irq));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_in);
		bus_req <= '0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe, so they are looked at there
	task automatic rd(input logic [15:0] a, input logic [7:0] ex, input string nm);
		@(posedge ref_clk_in);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_in);
		bus_req <= '0;
		#1;
		`CHK(nm, ex, rdata)
	endtask
	// partner register plus one cycle to the status bit
	task automatic evt(input ucb_pkg::ucb_link_evt_type e);
		@(posedge ref_clk_in);
		evt_req <= e;
		@(posedge ref_clk_in);
		evt_req <= '0;
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask
	function automatic ucb_pkg::ucb_link_evt_type mk(input int b, input logic [7:0] d);
		ucb_pkg::ucb_link_evt_type e;
		e = '0;
		e.tx_done  = (b == ucb_pkg::UCB_TX_END_BIT);
		e.rx_error = (b == ucb_pkg::UCB_RX_ERR_BIT);
		e.rx_push  = (b == ucb_pkg::UCB_RX_FULL_BIT);
		e.tx_start = (b == ucb_pkg::UCB_TX_EMPTY_BIT);
		e.rx_data  = d;
		return e;
	endfunction

	task automatic t_regs();
		rd(ucb_pkg::UCB_CTL_ADDR, 8'h00, "ctl reset");
		rd(ucb_pkg::UCB_EXP_ADDR, 8'h00, "exp reset");
		rd(ucb_pkg::UCB_BR_ADDR, 8'h00, "reload reset");
		rd(ucb_pkg::UCB_FMD_ADDR, 8'h00, "fine reset");
		rd(16'h4100, 8'h00, "unmapped");
		wr(ucb_pkg::UCB_EXP_ADDR, 8'hff);
		rd(ucb_pkg::UCB_EXP_ADDR, 8'h01, "exp mask");
		`CHK("infrared on", 1'b1, ir_mode)
		wr(ucb_pkg::UCB_EXP_ADDR, 8'h00);
		`CHK("infrared off", 1'b0, ir_mode)
		wr(ucb_pkg::UCB_FMD_ADDR, 8'hff);
		rd(ucb_pkg::UCB_FMD_ADDR, 8'h0f, "fine mask");
		wr(ucb_pkg::UCB_BR_ADDR, 8'ha5);
		rd(ucb_pkg::UCB_BR_ADDR, 8'ha5, "reload rw");
		wr(ucb_pkg::UCB_CTL_ADDR, 8'hfe);
		rd(ucb_pkg::UCB_CTL_ADDR, 8'hf2, "ctl mask");
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h00);
	endtask
	task automatic t_disabled();
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h77));
		`CHK("push while off", 1'b0, one_rdy)
		wr(ucb_pkg::UCB_TXD_ADDR, 8'h99);
		`CHK("tx while off", 1'b0, tx_valid)
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h00);
	endtask
	task automatic t_fifo();
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h01);
		`CHK("channel on", 1'b1, chan_en)
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h11));
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h22));
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h33));
		`CHK("two held", 1'b1, two_rdy)
		rd(ucb_pkg::UCB_RXD_ADDR, 8'h11, "oldest");
		`CHK("one left", 2'b01, {two_rdy, one_rdy})
		rd(ucb_pkg::UCB_RXD_ADDR, 8'h22, "second");
		`CHK("empty", 1'b0, one_rdy)
		rd(ucb_pkg::UCB_RXD_ADDR, 8'h00, "empty read");
		rd(ucb_pkg::UCB_IST_ADDR, 8'h20, "full status");
		rd(ucb_pkg::UCB_IST_ADDR, 8'h00, "status cleared");
	endtask
	task automatic t_thresh();
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h23);
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h44));
		`CHK("one of two", 1'b0, rx_full_irq)
		evt(mk(ucb_pkg::UCB_RX_FULL_BIT, 8'h55));
		`CHK("two of two", 1'b1, rx_full_irq)
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h03);
		`CHK("enable dropped", 1'b0, rx_full_irq)
		rd(ucb_pkg::UCB_RXD_ADDR, 8'h44, "drain a");
		rd(ucb_pkg::UCB_RXD_ADDR, 8'h55, "drain b");
		rd(ucb_pkg::UCB_IST_ADDR, 8'h20, "threshold status");
	endtask
	task automatic t_causes();
		for (int b = 4; b < 8; b++)
		begin
			wr(ucb_pkg::UCB_CTL_ADDR, 8'h01);
			if (b == ucb_pkg::UCB_TX_EMPTY_BIT)
				wr(ucb_pkg::UCB_TXD_ADDR, 8'h3c);
			evt(mk(b, 8'h5a));
			`CHK("masked line", 1'b0, lines[b-4])
			`CHK("masked irq", 1'b0, irq)
			rd(ucb_pkg::UCB_IST_ADDR, 8'h01 << b, "cause status");
			if (b == ucb_pkg::UCB_TX_EMPTY_BIT)
				wr(ucb_pkg::UCB_TXD_ADDR, 8'h3d);
			evt(mk(b, 8'h5a));
			wr(ucb_pkg::UCB_CTL_ADDR, 8'h01 | (8'h01 << b));
			`CHK("enabled line", 1'b1, lines[b-4])
			`CHK("enabled irq", 1'b1, irq)
			wr(ucb_pkg::UCB_CTL_ADDR, 8'h01);
			`CHK("cleared line", 1'b0, lines[b-4])
			rd(ucb_pkg::UCB_IST_ADDR, 8'h01 << b, "cause clear");
			if (b == ucb_pkg::UCB_RX_FULL_BIT)
			begin
				rd(ucb_pkg::UCB_RXD_ADDR, 8'h5a, "drain c");
				rd(ucb_pkg::UCB_RXD_ADDR, 8'h5a, "drain d");
			end
		end
	endtask
	task automatic t_tx_clear();
		wr(ucb_pkg::UCB_TXD_ADDR, 8'hc3);
		`CHK("tx waiting", 9'h1c3, {tx_valid, tx_data})
		rd(ucb_pkg::UCB_TXD_ADDR, 8'hc3, "tx readback");
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h00);
		`CHK("channel off", 1'b0, chan_en)
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h01);
		`CHK("tx discarded", 1'b0, tx_valid)
	endtask
	// with the enable low a register write is lost and the baud generator gives no tick
	task automatic t_freeze();
		@(posedge ref_clk_in);
		ce <= 1'b0;
		wr(ucb_pkg::UCB_EXP_ADDR, 8'h01);
		`CHK("frozen tick", 1'b0, sample_tick)
		`CHK("frozen write", 1'b0, ir_mode)
		@(posedge ref_clk_in);
		ce <= 1'b1;
		rd(ucb_pkg::UCB_EXP_ADDR, 8'h00, "frozen write lost");
	endtask
	task automatic t_baud(input logic [7:0] rl, input logic [3:0] fn, input logic [3:0] dv);
		int n;
		int ex;
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h00);
		wr(ucb_pkg::UCB_BR_ADDR, rl);
		wr(ucb_pkg::UCB_FMD_ADDR, {4'h0, fn});
		tick_div <= dv;
		wr(ucb_pkg::UCB_CTL_ADDR, 8'h01);
		n = 0;
		do begin @(negedge ref_clk_in); n++; end while (bit_tick !== 1'b1 && n < 9000);
		if (n >= 9000) begin miscompares++; test_done(); end
		for (int p = 1; p <= 16; p++)
		begin
			n = 0;
			do begin @(negedge ref_clk_in); n++; end while (sample_tick !== 1'b1 && n < 600);
			if (n >= 600) begin miscompares++; test_done(); end
			ex = (int'(rl) + 1 + int'(ucb_pkg::UCB_RANK[p-1] < fn)) * int'(dv);
			`CHK("sample period", ex, n)
			`CHK("bit tick", p == 16, bit_tick)
		end
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		`CHK("irq after reset", 1'b0, irq)
		t_regs();
		t_disabled();
		t_fifo();
		t_thresh();
		t_causes();
		t_tx_clear();
		t_freeze();
		t_baud(8'h02, 4'h0, 4'h1);
		t_baud(8'h02, 4'h1, 4'h1);
		t_baud(8'h03, 4'h8, 4'h1);
		t_baud(8'h01, 4'hf, 4'h2);
		test_done();
	end
endmodule // test_uart_ctrl_baud_generator
